// ===== fsp_defs.svh
// constants for the flash self-programming controller: register map, fields, keys, codes
// assumes a 32-bit classic wishbone slave port with word-aligned registers
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// ==========================================================
// register byte offsets
`define FSP_OFS_CTRL      5'h00
`define FSP_OFS_KEY       5'h04
`define FSP_OFS_TPAG      5'h08
`define FSP_OFS_EA        5'h0c
`define FSP_OFS_TLOW      5'h10
`define FSP_OFS_THIGH     5'h14
`define FSP_OFS_TMODE     5'h18

// ==========================================================
// control register fields and reset value
`define FSP_BIT_START     15
`define FSP_BIT_PROGRAM_ENABLE_BIT      14
`define FSP_BIT_ERR       13
`define FSP_BIT_ERASE     6
`define FSP_OPC_HI        3
`define FSP_CTRL_RST      16'h0000
`define FSP_BIT_BYTEMODE  0
`define FSP_BIT_CFGSPACE  7

// ==========================================================
// unlock keys
`define FSP_KEY_FIRST     8'h55
`define FSP_KEY_SECOND    8'haa

// ==========================================================
// operation codes
`define FSP_OPC_BULK      4'hf
`define FSP_OPC_GSEG      4'hd
`define FSP_OPC_SSEG      4'hc
`define FSP_OPC_WORD      4'h3
`define FSP_OPC_PAGE      4'h2
`define FSP_OPC_ROW       4'h1
`define FSP_OPC_CFG       4'h0

// ==========================================================
// array geometry and timing, in rc oscillator cycles
`define FSP_ROW_WORDS     64
`define FSP_ROW_LSB       7
`define FSP_PAGE_LSB      10
`define FSP_ROW_RC        16'd11064
`define FSP_WORD_RC       16'd1000
`define FSP_ERASE_RC      16'd8000
`define FSP_TBL_WAIT      1'b1

`endif

// ===== fsp_pkg.sv
// types shared by the flash self-programming controller
// assumes fsp_defs.svh is on the include path
`default_nettype none

package fsp_pkg;
	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STREAM,
		ST_WAIT
	} fsp_state_t;

	// ==========================================================
	// decoded operation
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ROW,
		OP_WORD,
		OP_PAGE,
		OP_ERASE_OTHER
	} fsp_kind_t;
endpackage

`default_nettype wire

// ===== fsp_flash_ctrl.sv
// flash self-programming controller: table access, holding buffer, unlock, op sequencer
// assumes a synchronous flash array with one-cycle reads and self-timed erase/program
// Function
// - address is table page joined to ea
// - low table access: bits 15:0, byte/word
// - high table access: bits 23:16, byte/word
// - rows of 64 words, pages of 512
// - erase whole page, program row or word
// - pages and rows aligned from address zero
// - buffer holds 64 aligned words, loaded in order
// - buffer table write takes two cycles
// - each row needs its own program cycle
// - core stalls while operation runs
// - duration counted in rc oscillator cycles
// - start bit launches, hardware clears at end
// - start only settable, reads busy state
// - keys 55h then aah required before start
// - key register write-only, reads zero
// - write enable permits, clear inhibits all
// - error flag set on improper start
// - erase bit picks erase or program variant
// - erase codes: bulk, segments, page, config
// - program codes: word, row, config byte
// - reserved and unlisted codes do nothing
// - control bits reset only on power-on
// - page msb selects configuration space
// - byte select one picks upper byte
// - phantom byte always reads zero
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`default_nettype none
`include "fsp_defs.svh"

module fsp_flash_ctrl #(
	parameter logic [15:0] ROW_RC_CYCLES   = `FSP_ROW_RC,
	parameter logic [15:0] WORD_RC_CYCLES  = `FSP_WORD_RC,
	parameter logic [15:0] ERASE_RC_CYCLES = `FSP_ERASE_RC
) (
	// clock and resets
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sys_rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// timing reference
	input  wire logic        rc_tick_i,
	// core stall
	output logic             cpu_stall_o,
	// flash array
	output logic      [23:0] flash_rd_addr_o,
	input  wire logic [23:0] flash_rdata_i,
	output logic             flash_wr_o,
	output logic             flash_erase_o,
	output logic      [3:0]  flash_op_code_o,
	output logic      [23:0] flash_op_addr_o,
	output logic      [23:0] flash_wr_data_o
);
	// ==========================================================
	// state
	logic                   ctrl_start, ctrl_program_enable_bit, ctrl_err, ctrl_erase;
	logic [3:0]             ctrl_opc;
	logic                   key_half, key_ok;
	logic [7:0]             table_page_reg;
	logic [15:0]            effective_addr;
	logic                   byte_mode;
	logic                   tbl_phase;
	fsp_pkg::fsp_state_t    state;
	fsp_pkg::fsp_kind_t     kind;
	logic [5:0]             idx;
	logic [15:0]            timer;
	logic [23:0]            hold_buf [`FSP_ROW_WORDS];

	logic                   next_ctrl_start, next_ctrl_program_enable_bit, next_ctrl_err, next_ctrl_erase;
	logic [3:0]             next_ctrl_opc;
	logic                   next_key_half, next_key_ok;
	logic [7:0]             next_table_page_reg;
	logic [15:0]            next_effective_addr;
	logic                   next_byte_mode, next_tbl_phase;
	fsp_pkg::fsp_state_t    next_state;
	fsp_pkg::fsp_kind_t     next_kind;
	logic [5:0]             next_idx;
	logic [15:0]            next_timer;
	logic [31:0]            next_dat;
	logic                   next_ack;
	logic [23:0]            next_rd_addr, next_op_addr, next_wr_data;
	logic                   next_flash_wr, next_flash_erase, next_stall;
	logic [3:0]             next_op_code;
	logic                   buf_we;
	logic [5:0]             buf_idx;
	logic [23:0]            buf_mask, buf_wdata;

	// ==========================================================
	// combinational helpers
	logic        req, wr, rd;
	logic [23:0] tgt_addr, row_base, page_base;
	logic [15:0] rd_lo;
	logic [15:0] limit;
	fsp_pkg::fsp_kind_t dec_kind;

	assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr        = req & wb_we_i;
	assign rd        = req & ~wb_we_i;
	assign tgt_addr  = {table_page_reg, effective_addr};
	assign row_base  = {tgt_addr[23:`FSP_ROW_LSB], {`FSP_ROW_LSB{1'b0}}};
	assign page_base = {tgt_addr[23:`FSP_PAGE_LSB], {`FSP_PAGE_LSB{1'b0}}};
	assign rd_lo     = flash_rdata_i[15:0];

	// ==========================================================
	// operation decode from erase select and code
	always_comb begin
		dec_kind = fsp_pkg::OP_NONE;
		if (ctrl_erase) begin
			case (ctrl_opc)
				`FSP_OPC_BULK: dec_kind = fsp_pkg::OP_ERASE_OTHER;
				`FSP_OPC_GSEG: dec_kind = fsp_pkg::OP_ERASE_OTHER;
				`FSP_OPC_SSEG: dec_kind = fsp_pkg::OP_ERASE_OTHER;
				`FSP_OPC_PAGE: dec_kind = fsp_pkg::OP_PAGE;
				`FSP_OPC_CFG:  dec_kind = fsp_pkg::OP_ERASE_OTHER;
				default:       dec_kind = fsp_pkg::OP_NONE;
			endcase
		end else begin
			case (ctrl_opc)
				`FSP_OPC_WORD: dec_kind = fsp_pkg::OP_WORD;
				`FSP_OPC_ROW:  dec_kind = fsp_pkg::OP_ROW;
				`FSP_OPC_CFG:  dec_kind = fsp_pkg::OP_WORD;
				default:       dec_kind = fsp_pkg::OP_NONE;
			endcase
		end
	end

	// duration picked per operation; with the default timings a row takes the longest
	always_comb begin
		case (kind)
			fsp_pkg::OP_ROW:  limit = ROW_RC_CYCLES;
			fsp_pkg::OP_WORD: limit = WORD_RC_CYCLES;
			default:          limit = ERASE_RC_CYCLES;
		endcase
	end

	// ==========================================================
	// next-state logic for bus, registers, buffer and sequencer
	always_comb begin
		next_ctrl_start     = ctrl_start;
		next_ctrl_program_enable_bit      = ctrl_program_enable_bit;
		next_ctrl_err       = ctrl_err;
		next_ctrl_erase     = ctrl_erase;
		next_ctrl_opc       = ctrl_opc;
		next_key_half       = key_half;
		next_key_ok         = key_ok;
		next_table_page_reg = table_page_reg;
		next_effective_addr = effective_addr;
		next_byte_mode      = byte_mode;
		next_tbl_phase      = 1'b0;
		next_state          = state;
		next_kind           = kind;
		next_idx            = idx;
		next_timer          = timer;
		next_dat            = wb_dat_o;
		next_ack            = 1'b0;
		next_rd_addr        = flash_rd_addr_o;
		next_op_addr        = flash_op_addr_o;
		next_wr_data        = flash_wr_data_o;
		next_op_code        = flash_op_code_o;
		next_flash_wr       = 1'b0;
		next_flash_erase    = 1'b0;
		buf_we              = 1'b0;
		buf_idx             = effective_addr[6:1];
		buf_mask            = 24'h000000;
		buf_wdata           = 24'h000000;

		// bus side; table accesses take a second cycle for the array read
		if (req) begin
			case (wb_adr_i)
				`FSP_OFS_CTRL: begin
					next_ack = 1'b1;
					next_dat = {16'h0000, ctrl_start, ctrl_program_enable_bit, ctrl_err, 6'h00,
						ctrl_erase, 2'h0, ctrl_opc};
					if (wr && state == fsp_pkg::ST_IDLE && !ctrl_start) begin
						if (wb_sel_i[0]) begin
							next_ctrl_erase = wb_dat_i[`FSP_BIT_ERASE];
							next_ctrl_opc   = wb_dat_i[`FSP_OPC_HI:0];
						end
						if (wb_sel_i[1]) begin
							next_ctrl_program_enable_bit = wb_dat_i[`FSP_BIT_PROGRAM_ENABLE_BIT];
							next_ctrl_err  = wb_dat_i[`FSP_BIT_ERR];
							if (wb_dat_i[`FSP_BIT_START]) begin
								next_key_ok   = 1'b0;
								next_key_half = 1'b0;
								if (!key_ok || !wb_dat_i[`FSP_BIT_PROGRAM_ENABLE_BIT]) begin
									next_ctrl_err = 1'b1;
								end else begin
									next_ctrl_err = 1'b0;
									if (dec_kind != fsp_pkg::OP_NONE) begin
										next_ctrl_start = 1'b1;
										next_kind       = dec_kind;
										next_idx        = 6'h00;
										next_timer      = 16'h0000;
										next_op_code    = ctrl_opc;
										next_state      = fsp_pkg::ST_STREAM;
									end
								end
							end
						end
					end
				end
				`FSP_OFS_KEY: begin
					next_ack = 1'b1;
					next_dat = 32'h00000000;
					if (wr && wb_sel_i[0]) begin
						// any other key value breaks the pair
						next_key_half = (wb_dat_i[7:0] == `FSP_KEY_FIRST);
						next_key_ok   = key_half && (wb_dat_i[7:0] == `FSP_KEY_SECOND);
					end
				end
				`FSP_OFS_TPAG: begin
					next_ack = 1'b1;
					next_dat = {24'h000000, table_page_reg};
					if (wr && wb_sel_i[0])
						next_table_page_reg = wb_dat_i[7:0];
				end
				`FSP_OFS_EA: begin
					next_ack = 1'b1;
					next_dat = {16'h0000, effective_addr};
					if (wr) begin
						if (wb_sel_i[0])
							next_effective_addr[7:0] = wb_dat_i[7:0];
						if (wb_sel_i[1])
							next_effective_addr[15:8] = wb_dat_i[15:8];
					end
				end
				`FSP_OFS_TMODE: begin
					next_ack = 1'b1;
					next_dat = {31'h00000000, byte_mode};
					if (wr && wb_sel_i[0])
						next_byte_mode = wb_dat_i[`FSP_BIT_BYTEMODE];
				end
				`FSP_OFS_TLOW, `FSP_OFS_THIGH: begin
					next_rd_addr   = tgt_addr;
					next_tbl_phase = ~tbl_phase;
					if (tbl_phase == `FSP_TBL_WAIT) begin
						next_ack       = 1'b1;
						next_tbl_phase = 1'b0;
						next_dat       = 32'h00000000;
						if (wb_adr_i == `FSP_OFS_TLOW) begin
							if (!byte_mode)
								next_dat[15:0] = rd_lo;
							else if (effective_addr[0])
								next_dat[7:0] = rd_lo[15:8];
							else
								next_dat[7:0] = rd_lo[7:0];
						end else if (!(byte_mode && effective_addr[0])) begin
							next_dat[7:0] = flash_rdata_i[23:16];
						end
						// only the buffer is written, never the array
						if (wr) begin
							buf_we = 1'b1;
							if (wb_adr_i == `FSP_OFS_TLOW) begin
								buf_wdata = {8'h00, wb_dat_i[15:0]};
								if (!byte_mode)
									buf_mask = 24'h00ffff;
								else if (effective_addr[0]) begin
									buf_mask  = 24'h00ff00;
									buf_wdata = {8'h00, wb_dat_i[7:0], 8'h00};
								end else
									buf_mask = 24'h0000ff;
							end else begin
								// the phantom byte cannot be written
								buf_wdata = {wb_dat_i[7:0], 16'h0000};
								buf_mask  = (byte_mode && effective_addr[0]) ? 24'h000000
									: 24'hff0000;
							end
						end
					end
				end
				default: begin
					next_ack = 1'b1;
					next_dat = 32'h00000000;
				end
			endcase
		end

		// sequencer; software cannot end an operation early
		case (state)
			fsp_pkg::ST_IDLE: begin
				next_idx = 6'h00;
			end
			fsp_pkg::ST_STREAM: begin
				case (kind)
					fsp_pkg::OP_ROW: begin
						// copy the whole 64-word buffer into the aligned row
						next_flash_wr = 1'b1;
						next_op_addr  = row_base | {17'h00000, idx, 1'b0};
						next_wr_data  = hold_buf[idx];
						next_idx      = idx + 6'h01;
						if (idx == 6'(`FSP_ROW_WORDS - 1))
							next_state = fsp_pkg::ST_WAIT;
					end
					fsp_pkg::OP_WORD: begin
						next_flash_wr = 1'b1;
						next_op_addr  = tgt_addr;
						next_wr_data  = hold_buf[effective_addr[6:1]];
						next_state    = fsp_pkg::ST_WAIT;
					end
					fsp_pkg::OP_PAGE: begin
						next_flash_erase = 1'b1;
						next_op_addr     = page_base;
						next_state       = fsp_pkg::ST_WAIT;
					end
					default: begin
						next_flash_erase = 1'b1;
						next_op_addr     = tgt_addr;
						next_state       = fsp_pkg::ST_WAIT;
					end
				endcase
			end
			fsp_pkg::ST_WAIT: begin
				if (rc_tick_i) begin
					next_timer = timer + 16'h0001;
					if (timer == limit - 16'h0001) begin
						next_ctrl_start = 1'b0;
						next_state      = fsp_pkg::ST_IDLE;
					end
				end
			end
			default: next_state = fsp_pkg::ST_IDLE;
		endcase

		// the core waits while the start bit is up
		next_stall = next_ctrl_start;
	end

	// ==========================================================
	// control bits: cleared by power-on reset only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_start <= 1'(`FSP_CTRL_RST >> `FSP_BIT_START);
			ctrl_program_enable_bit  <= 1'b0;
			ctrl_err   <= 1'b0;
			ctrl_erase <= 1'b0;
			ctrl_opc   <= 4'h0;
			state      <= fsp_pkg::ST_IDLE;
			kind       <= fsp_pkg::OP_NONE;
			idx        <= 6'h00;
			timer      <= 16'h0000;
			cpu_stall_o <= 1'b0;
			flash_wr_o <= 1'b0;
			flash_erase_o <= 1'b0;
			flash_op_code_o <= 4'h0;
			flash_op_addr_o <= 24'h000000;
			flash_wr_data_o <= 24'h000000;
		end else begin
			ctrl_start <= next_ctrl_start;
			ctrl_program_enable_bit  <= next_ctrl_program_enable_bit;
			ctrl_err   <= next_ctrl_err;
			ctrl_erase <= next_ctrl_erase;
			ctrl_opc   <= next_ctrl_opc;
			state      <= next_state;
			kind       <= next_kind;
			idx        <= next_idx;
			timer      <= next_timer;
			cpu_stall_o <= next_stall;
			flash_wr_o <= next_flash_wr;
			flash_erase_o <= next_flash_erase;
			flash_op_code_o <= next_op_code;
			flash_op_addr_o <= next_op_addr;
			flash_wr_data_o <= next_wr_data;
		end
	end

	// ==========================================================
	// bus, key and table pointer: any reset source clears them
	always_ff @(posedge clk_i) begin
		if (rst_i || sys_rst_i) begin
			key_half        <= 1'b0;
			key_ok          <= 1'b0;
			table_page_reg  <= 8'h00;
			effective_addr  <= 16'h0000;
			byte_mode       <= 1'b0;
			tbl_phase       <= 1'b0;
			wb_ack_o        <= 1'b0;
			wb_dat_o        <= 32'h00000000;
			flash_rd_addr_o <= 24'h000000;
		end else begin
			key_half        <= next_key_half;
			key_ok          <= next_key_ok;
			table_page_reg  <= next_table_page_reg;
			effective_addr  <= next_effective_addr;
			byte_mode       <= next_byte_mode;
			tbl_phase       <= next_tbl_phase;
			wb_ack_o        <= next_ack;
			wb_dat_o        <= next_dat;
			flash_rd_addr_o <= next_rd_addr;
		end
	end

	// ==========================================================
	// holding buffer; contents survive resets, like the array latches
	always_ff @(posedge clk_i) begin
		if (buf_we)
			hold_buf[buf_idx] <= (hold_buf[buf_idx] & ~buf_mask) | (buf_wdata & buf_mask);
	end
endmodule // fsp_flash_ctrl

`default_nettype wire

// ===== fsp_flash_ctrl_sva.sv
// checker for the flash self-programming controller, bound to its ports
// assumes one clock, rst_i synchronous active high
`default_nettype none

module fsp_flash_ctrl_sva (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// wishbone
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// core and array
	input wire logic        cpu_stall_o,
	input wire logic        flash_wr_o,
	input wire logic        flash_erase_o,
	input wire logic [3:0]  flash_op_code_o,
	input wire logic [23:0] flash_op_addr_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ==========================================================
	// array writes within one operation
	logic [6:0] n_wr;
	logic [6:0] next_n_wr;
	// cleared between operations so a runaway row shows as an overflow
	always_comb begin
		next_n_wr = cpu_stall_o ? n_wr + {6'h0, flash_wr_o} : 7'h0;
	end
	always_ff @(posedge clk_i) begin
		n_wr <= rst_i ? 7'h0 : next_n_wr;
	end

	// ==========================================================
	// assertions
	chk_tbl_two_cycle: assert property (wb_ack_o && (wb_adr_i == 5'h10 || wb_adr_i == 5'h14)
		|-> $past(wb_stb_i) && !$past(wb_ack_o) && $past(wb_stb_i, 2))
		else $error("table access not answered in two cycles");
	chk_key_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h04
		|-> wb_dat_o == 32'h0) else $error("key register read not zero");
	chk_phantom_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h14
		|-> wb_dat_o[31:8] == 24'h0) else $error("phantom byte not zero");
	chk_start_reads: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h00
		|-> wb_dat_o[15] == $past(cpu_stall_o) && wb_dat_o[12:7] == 6'h0)
		else $error("start bit read differs from busy state");
	chk_stall_cause: assert property ($rose(cpu_stall_o)
		|-> $past(wb_stb_i && wb_we_i && wb_adr_i == 5'h00 && !wb_ack_o))
		else $error("stall rose without a control write");
	chk_array_in_op: assert property (flash_wr_o || flash_erase_o |-> cpu_stall_o)
		else $error("array touched outside an operation");
	chk_page_base: assert property (flash_erase_o && flash_op_code_o == 4'h2
		|-> flash_op_addr_o[9:0] == 10'h0) else $error("page erase not page aligned");
	chk_row_count: assert property (n_wr <= 7'd64)
		else $error("more than one row written");
	chk_erase_single: assert property (flash_erase_o |=> !flash_erase_o && !flash_wr_o)
		else $error("erase not a single pulse");
endmodule // fsp_flash_ctrl_sva

bind fsp_flash_ctrl fsp_flash_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .cpu_stall_o(cpu_stall_o), .flash_wr_o(flash_wr_o),
	.flash_erase_o(flash_erase_o), .flash_op_code_o(flash_op_code_o),
	.flash_op_addr_o(flash_op_addr_o));

`default_nettype wire

// ===== fsp_array_model.sv
// flash array stand-in: data from the word address, counts writes and erases
// assumes the controller's flash outputs are registered to clk_i
`default_nettype none

module fsp_array_model (
	// clock
	input  wire logic        clk_i,
	// from the controller
	input  wire logic [23:0] rd_addr_i,
	input  wire logic        wr_i,
	input  wire logic        erase_i,
	input  wire logic [23:0] op_addr_i,
	input  wire logic [23:0] wr_data_i,
	// to the controller
	output logic      [23:0] rdata_o,
	output logic             tick_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned n_wr    = 0;
	int unsigned n_er    = 0;
	logic [23:0] wr_addr = 24'h0;
	logic [23:0] wr_data = 24'h0;
	logic [23:0] er_addr = 24'h0;
	logic [1:0]  div     = 2'h0;

	// byte select ignored: a word reads the same for either byte
	assign rdata_o = {rd_addr_i[23:1], 1'b0} ^ 24'ha5c33c;
	// oscillator stand-in, one tick every third clock
	assign tick_o = (div == 2'h2);

	// divider and record of array activity
	always @(posedge clk_i) begin
		div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
		if (wr_i) begin
			n_wr <= n_wr + 1;
			wr_addr <= op_addr_i;
			wr_data <= wr_data_i;
		end
		if (erase_i) begin
			n_er <= n_er + 1;
			er_addr <= op_addr_i;
		end
	end
endmodule // fsp_array_model

`default_nettype wire

// ===== fsp_flash_ctrl_tb.sv
// self-checking bench for the flash self-programming controller
// assumes fsp_array_model as the array and the bound checker
`default_nettype none
`include "fsp_defs.svh"

module fsp_flash_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// signals
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        srst  = 1'b0;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [4:0]  adr   = 5'h00;
	logic [31:0] wdat  = 32'h0;
	logic [31:0] rdat, got;
	logic        ack, tick, stall, fwr, fer, lau;
	logic [23:0] rd_addr, rdata, op_addr, wr_data, x;
	logic [3:0]  op_code;
	logic [15:0] cv;
	logic [7:0]  pg [2] = '{8'h01, 8'h80};
	int          n_fail  = 0;
	int          checked = 0;
	int          ew, ee;

	always #10 clk_i = ~clk_i;

	// ==========================================================
	// design and array; short op times keep the run brief
	fsp_flash_ctrl #(.ROW_RC_CYCLES(16'd4), .WORD_RC_CYCLES(16'd6),
		.ERASE_RC_CYCLES(16'd6)) DUT (.clk_i(clk_i), .rst_i(rst_i), .sys_rst_i(srst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rc_tick_i(tick),
		.cpu_stall_o(stall), .flash_rd_addr_o(rd_addr), .flash_rdata_i(rdata),
		.flash_wr_o(fwr), .flash_erase_o(fer), .flash_op_code_o(op_code),
		.flash_op_addr_o(op_addr), .flash_wr_data_o(wr_data));
	fsp_array_model model (.clk_i(clk_i), .rd_addr_i(rd_addr), .wr_i(fwr), .erase_i(fer),
		.op_addr_i(op_addr), .wr_data_i(wr_data), .rdata_o(rdata), .tick_o(tick));

	// ==========================================================
	// tasks
	task automatic wrap_up();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one classic cycle, held until the edge that samples ack
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk_i);
		if (ack !== 1'b1) begin
			n_fail++;
			wrap_up();
		end
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic unlock();
		bus(1'b1, `FSP_OFS_KEY, 32'h55);
		bus(1'b1, `FSP_OFS_KEY, 32'haa);
	endtask

	// bounded wait for the running operation to end
	task automatic wait_idle();
		int i;
		for (i = 0; i < 2000 && stall !== 1'b0; i++) @(posedge clk_i);
		if (stall !== 1'b0) begin
			n_fail++;
			wrap_up();
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("ctrl reset", 32'h0, got);
		bus(1'b1, `FSP_OFS_KEY, 32'h1234);
		bus(1'b0, `FSP_OFS_KEY, 32'h0);
		cmp("key read", 32'h0, got);
		bus(1'b1, 5'h1c, 32'hffff);
		bus(1'b0, 5'h1c, 32'h0);
		cmp("unmapped", 32'h0, got);
		// table reads in user and configuration space
		for (int p = 0; p < 2; p++) begin
			x = {pg[p], 16'h0124} ^ 24'ha5c33c;
			bus(1'b1, `FSP_OFS_TPAG, {24'h0, pg[p]});
			bus(1'b1, `FSP_OFS_EA, 32'h0124);
			bus(1'b1, `FSP_OFS_TMODE, 32'h0);
			bus(1'b0, `FSP_OFS_TLOW, 32'h0);
			cmp("low word", {16'h0, x[15:0]}, got);
			cmp("read addr", {8'h0, pg[p], 16'h0124}, {8'h0, rd_addr});
			bus(1'b0, `FSP_OFS_THIGH, 32'h0);
			cmp("high word", {24'h0, x[23:16]}, got);
			bus(1'b1, `FSP_OFS_TMODE, 32'h1);
			bus(1'b0, `FSP_OFS_TLOW, 32'h0);
			cmp("low byte", {24'h0, x[7:0]}, got);
			bus(1'b1, `FSP_OFS_EA, 32'h0125);
			bus(1'b0, `FSP_OFS_TLOW, 32'h0);
			cmp("upper byte", {24'h0, x[15:8]}, got);
			bus(1'b0, `FSP_OFS_THIGH, 32'h0);
			cmp("phantom", 32'h0, got);
		end
		bus(1'b1, `FSP_OFS_TPAG, 32'h0);
		bus(1'b1, `FSP_OFS_TMODE, 32'h0);
		// refused starts: no keys, write enable clear, broken pair
		bus(1'b1, `FSP_OFS_CTRL, 32'hc001);
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("no unlock", 32'h6001, got);
		bus(1'b1, `FSP_OFS_CTRL, 32'h0001);
		unlock();
		bus(1'b1, `FSP_OFS_CTRL, 32'h8001);
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("program_enable_bit clear", 32'h2001, got);
		bus(1'b1, `FSP_OFS_KEY, 32'h55);
		bus(1'b1, `FSP_OFS_KEY, 32'h00);
		bus(1'b1, `FSP_OFS_KEY, 32'haa);
		bus(1'b1, `FSP_OFS_CTRL, 32'hc001);
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("broken pair", 32'h6001, got);
		// fill one aligned row of buffers in order
		for (int i = 0; i < 64; i++) begin
			bus(1'b1, `FSP_OFS_EA, 32'h0480 + 2 * i);
			bus(1'b1, `FSP_OFS_TLOW, 32'h1000 + i);
			bus(1'b1, `FSP_OFS_THIGH, 32'h40 + i);
		end
		cmp("array untouched", 32'h0, model.n_wr);
		bus(1'b1, `FSP_OFS_EA, 32'h0486);
		// every code with erase and program selected
		for (int e = 0; e < 2; e++) begin
			for (int c = 0; c < 16; c++) begin
				cv = 16'h4000 | (e == 1 ? 16'h0040 : 16'h0) | {12'h0, c[3:0]};
				ew = (e == 0 && c == 1) ? 64 : (e == 0 && (c == 3 || c == 0)) ? 1 : 0;
				ee = (e == 1 && c inside {15, 13, 12, 2, 0}) ? 1 : 0;
				lau = (ew + ee) > 0;
				ew += model.n_wr;
				ee += model.n_er;
				bus(1'b1, `FSP_OFS_CTRL, {16'h0, cv});
				unlock();
				bus(1'b1, `FSP_OFS_CTRL, {16'h0, cv | 16'h8000});
				bus(1'b0, `FSP_OFS_CTRL, 32'h0);
				cmp("busy read", {16'h0, cv | (lau ? 16'h8000 : 16'h0)}, got);
				cmp("stall", {31'h0, lau}, {31'h0, stall});
				if (lau) bus(1'b1, `FSP_OFS_CTRL, 32'h0);
				wait_idle();
				bus(1'b0, `FSP_OFS_CTRL, 32'h0);
				cmp("after op", {16'h0, cv}, got);
				cmp("writes", ew, model.n_wr);
				cmp("erases", ee, model.n_er);
				if (lau) cmp("op code", {28'h0, c[3:0]}, {28'h0, op_code});
				if (e == 0 && c == 1) cmp("row end", 32'h0004fe, model.wr_addr);
				if (e == 0 && c == 3) cmp("word data", 32'h431003, model.wr_data);
				if (e == 1 && c == 2) cmp("page base", 32'h000400, model.er_addr);
			end
		end
		bus(1'b1, `FSP_OFS_CTRL, 32'hc04f);
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("unlock reused", 32'h604f, got);
		// other reset: control kept, keys lost
		unlock();
		@(posedge clk_i);
		srst <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst <= 1'b0;
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("ctrl kept", 32'h604f, got);
		bus(1'b1, `FSP_OFS_CTRL, 32'hc04f);
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("keys cleared", 32'h604f, got);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, `FSP_OFS_CTRL, 32'h0);
		cmp("power-on clear", 32'h0, got);
		wrap_up();
	end
endmodule // fsp_flash_ctrl_tb

`default_nettype wire
